// ==== logic/wdcu_defines.vh ====
// constants for the watchdog control unit: register map, field positions,
// reset values, vectors and timing counts.
// assumes a 125 MHz aclk and an AXI4-Lite master with 32-bit data.
//
// Summary of operation
// - time-out in interrupt mode sets flag bit 7
// - taking watchdog vector clears the flag
// - writing one clears flag, zero keeps
// - request irq when flag, enable, global enable
// - enable bits select stop/irq/reset/combined modes
// - combined mode vector clears enable and flag
// - combined mode unserved second time-out resets
// - clear reset-enable or period only when unlocked
// - unlock bit self-clears after four clocks
// - cause flag forces reset-enable to one
// - period field bits 5 and 2..0
// - codes 0..9 give 2048 to 1048576 cycles
// - reset vector 0x0000, time-out vector 0x0012
// - fuse forces reset-only, enables locked
// - count oscillator ticks, restart clears counter
`ifndef WDCU_DEFINES_VH
`define WDCU_DEFINES_VH

// -----------------------------------------------------------------
// register map (byte addresses)
// -----------------------------------------------------------------
`define WDCU_ADDR_CTRL      5'h00
`define WDCU_ADDR_CAUSE     5'h04
`define WDCU_ADDR_IRQ_STAT  5'h08
`define WDCU_ADDR_IRQ_MASK  5'h0c
`define WDCU_ADDR_STATUS    5'h10

// -----------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------
`define WDCU_BIT_FLAG       7
`define WDCU_BIT_IE         6
`define WDCU_BIT_P3         5
`define WDCU_BIT_UNLOCK     4
`define WDCU_BIT_RE         3
`define WDCU_CTRL_RESET     8'h00
`define WDCU_PERIOD_MAX     4'h9
`define WDCU_CNT_W          21
`define WDCU_BASE_LOG2      11

// -----------------------------------------------------------------
// vectors, axi responses, timing
// -----------------------------------------------------------------
`define WDCU_VEC_RESET      16'h0000
`define WDCU_VEC_TIMEOUT    16'h0012
`define WDCU_RESP_OKAY      2'h0
`define WDCU_RESP_SLVERR    2'h2
`define WDCU_UNLOCK_CYCLES  3'h4
`define WDCU_IRQ_EVENTS     2

`endif

// ==== logic/wdcu_unlock_timer.v ====
// unlock window timer: holds the change-unlock bit for four clocks.
// assumes start is a one-cycle pulse from a register write.
`timescale 1ns/100ps
`include "wdcu_defines.vh"

module wdcu_unlock_timer (
   input  wire aclk,     // system clock
   input  wire aresetn,  // synchronous reset, low
   input  wire start,    // write of one to unlock bit
   output wire unlock    // unlock window open
);

   reg [2:0] left_ff;
   reg [2:0] nxt_left;

   // -----------------------------------------------------------------
   // down counter
   // -----------------------------------------------------------------
   // reload on start, count to zero
   always @*
   begin
      nxt_left = left_ff;
      if (start)
         nxt_left = `WDCU_UNLOCK_CYCLES;
      else if (left_ff != 3'h0)
         nxt_left = left_ff - 3'h1;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         left_ff <= 3'h0;
      else
         left_ff <= nxt_left;
   end

   assign unlock = (left_ff != 3'h0);

endmodule

// ==== logic/wdcu_timeout_counter.v ====
// time-out counter: counts oscillator ticks against the selected period.
// assumes osc_tick is a one-cycle pulse per low-frequency oscillator cycle.
`timescale 1ns/100ps
`include "wdcu_defines.vh"

module wdcu_timeout_counter (
   input  wire       aclk,      // system clock
   input  wire       aresetn,   // synchronous reset, low
   input  wire       run,       // watchdog running
   input  wire       osc_tick,  // oscillator cycle pulse
   input  wire       restart,   // restart instruction pulse
   input  wire [3:0] period,    // period select code
   output wire       timeout    // one-cycle time-out pulse
);

   reg  [`WDCU_CNT_W-1:0] cnt_ff;
   wire [`WDCU_CNT_W-1:0] limit;
   wire [3:0]             code;

   // reserved codes fall back to the longest period
   assign code  = (period > `WDCU_PERIOD_MAX) ? `WDCU_PERIOD_MAX : period;
   // 2048 << code, minus one as terminal count
   assign limit = ({{(`WDCU_CNT_W-1){1'b0}}, 1'b1} << (code + `WDCU_BASE_LOG2)) - 1'b1;

   assign timeout = run && osc_tick && (cnt_ff >= limit);

   // -----------------------------------------------------------------
   // tick counter
   // -----------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn || restart || !run)
         cnt_ff <= {`WDCU_CNT_W{1'b0}};
      else if (osc_tick)
         cnt_ff <= timeout ? {`WDCU_CNT_W{1'b0}} : cnt_ff + 1'b1;
   end

endmodule

// ==== logic/wdcu_watchdog_control_unit.v ====
// watchdog control unit top: control register, mode logic and axi4-lite slave.
// assumes the cpu side gives global enable, vector fetch and restart pulses,
// and that a caller acts on sys_reset_req by resetting the whole system.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "wdcu_defines.vh"

module wdcu_watchdog_control_unit (
   input  wire        aclk,             // system clock, 125 MHz
   input  wire        aresetn,          // synchronous reset, low
   input  wire        wd_always_on_fuse,// fuse programmed
   input  wire        cpu_global_ie,    // global interrupt enable
   input  wire        vector_taken,     // watchdog vector executed
   input  wire        wd_restart,       // restart instruction
   input  wire        osc_tick,         // 128 kHz oscillator pulse
   input  wire        awvalid,          // write address valid
   output wire        awready,          // write address ready
   input  wire [31:0] awaddr,           // write address
   input  wire        wvalid,           // write data valid
   output wire        wready,           // write data ready
   input  wire [31:0] wdata,            // write data
   input  wire [3:0]  wstrb,            // write strobes
   output reg         bvalid,           // write response valid
   input  wire        bready,           // write response ready
   output reg  [1:0]  bresp,            // write response
   input  wire        arvalid,          // read address valid
   output wire        arready,          // read address ready
   input  wire [31:0] araddr,           // read address
   output reg         rvalid,           // read data valid
   input  wire        rready,           // read data ready
   output reg  [31:0] rdata,            // read data
   output reg  [1:0]  rresp,            // read response
   output wire        wd_irq_req,       // watchdog interrupt request
   output wire [15:0] wd_vector_addr,   // vector for current request
   output reg         sys_reset_req,    // system reset request
   output wire        irq               // summary interrupt, level
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   reg        flag_ff;
   reg        ie_ff;
   reg        re_ff;
   reg  [3:0] period_ff;
   reg        cause_ff;
   reg  [1:0] stat_ff;
   reg  [1:0] mask_ff;
   reg        aw_ff;
   reg        w_ff;
   reg [31:0] awaddr_ff;
   reg [31:0] wdata_ff;
   reg  [3:0] wstrb_ff;
   reg        nxt_flag;
   reg        nxt_ie;
   reg        nxt_re;
   reg  [3:0] nxt_period;
   reg        nxt_cause;
   reg  [1:0] nxt_stat;
   reg  [1:0] nxt_mask;

   wire       unlock;
   wire       timeout;
   wire       run;
   wire       eff_re;
   wire       eff_ie;
   wire       wr_fire;
   wire       unlock_start;
   wire [7:0] ctrl_rd;
   wire [7:0] wb;

   // decode register index from an address
   function [4:0] reg_sel;
      input [31:0] a;
      begin
         reg_sel = a[4:0];
         if (a[31:5] != 27'h0)
            reg_sel = 5'h01;
      end
   endfunction

   // register is mapped
   function mapped;
      input [31:0] a;
      begin
         mapped = (a[31:5] == 27'h0) && (a[1:0] == 2'h0) && (a[4:2] <= 3'h4);
      end
   endfunction

   // -----------------------------------------------------------------
   // mode selection
   // -----------------------------------------------------------------
   // fuse locks reset-enable high and irq-enable low
   assign eff_re = wd_always_on_fuse | re_ff | cause_ff;
   assign eff_ie = ~wd_always_on_fuse & ie_ff;
   assign run    = eff_re | eff_ie;

   wdcu_timeout_counter u_counter (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (run),
      .osc_tick (osc_tick),
      .restart  (wd_restart),
      .period   (period_ff),
      .timeout  (timeout)
   );

   // -----------------------------------------------------------------
   // axi write channel capture
   // -----------------------------------------------------------------
   assign awready = ~aw_ff & ~bvalid;
   assign wready  = ~w_ff & ~bvalid;
   assign wr_fire = aw_ff & w_ff & ~bvalid;
   assign wb      = wstrb_ff[0] ? wdata_ff[7:0] : ctrl_rd;
   assign unlock_start = wr_fire && reg_sel(awaddr_ff) == `WDCU_ADDR_CTRL && wstrb_ff[0]
                         && wdata_ff[`WDCU_BIT_UNLOCK];

   wdcu_unlock_timer u_unlock (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (unlock_start),
      .unlock  (unlock)
   );

   // address and data taken in either order, response after both
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ff     <= 1'b0;
         w_ff      <= 1'b0;
         awaddr_ff <= 32'h0;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= `WDCU_RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_ff     <= 1'b1;
            awaddr_ff <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_ff     <= 1'b1;
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
         end
         if (wr_fire)
         begin
            aw_ff  <= 1'b0;
            w_ff   <= 1'b0;
            bvalid <= 1'b1;
            bresp  <= mapped(awaddr_ff) ? `WDCU_RESP_OKAY : `WDCU_RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // control register next state
   // -----------------------------------------------------------------
   always @*
   begin
      nxt_flag   = flag_ff;
      nxt_ie     = ie_ff;
      nxt_re     = re_ff;
      nxt_period = period_ff;
      nxt_cause  = cause_ff;
      nxt_stat   = stat_ff;
      nxt_mask   = mask_ff;
      sys_reset_next_calc;
      // software writes first so hardware events win
      if (wr_fire && wstrb_ff[0])
      begin
         case (reg_sel(awaddr_ff))
            `WDCU_ADDR_CTRL:
            begin
               if (wb[`WDCU_BIT_FLAG])
                  nxt_flag = 1'b0;
               nxt_ie = wb[`WDCU_BIT_IE];
               if (wb[`WDCU_BIT_RE])
                  nxt_re = 1'b1;
               else if (unlock && !cause_ff)
                  nxt_re = 1'b0;
               if (unlock)
                  nxt_period = {wb[`WDCU_BIT_P3], wb[2:0]};
            end
            `WDCU_ADDR_CAUSE:
               nxt_cause = wb[0];
            `WDCU_ADDR_IRQ_STAT:
               nxt_stat = stat_ff & ~wb[1:0];
            `WDCU_ADDR_IRQ_MASK:
               nxt_mask = wb[1:0];
            default:
               nxt_mask = nxt_mask;
         endcase
      end
      // vector execution clears flag, and irq enable in combined mode
      if (vector_taken && wd_irq_req)
      begin
         nxt_flag = 1'b0;
         if (eff_re)
            nxt_ie = 1'b0;
      end
      if (timeout)
      begin
         if (eff_ie && !(eff_re && flag_ff))
         begin
            nxt_flag    = 1'b1;
            nxt_stat[0] = 1'b1;
         end
         else if (eff_re)
         begin
            nxt_cause   = 1'b1;
            nxt_stat[1] = 1'b1;
         end
      end
   end

   task sys_reset_next_calc;
      begin
      end
   endtask

   // -----------------------------------------------------------------
   // register update
   // -----------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flag_ff   <= 1'b0;
         ie_ff     <= 1'b0;
         re_ff     <= 1'b0;
         period_ff <= 4'h0;
         cause_ff  <= 1'b0;
         stat_ff   <= 2'h0;
         mask_ff   <= 2'h0;
      end
      else
      begin
         flag_ff   <= nxt_flag;
         ie_ff     <= nxt_ie;
         re_ff     <= nxt_re;
         period_ff <= nxt_period;
         cause_ff  <= nxt_cause;
         stat_ff   <= nxt_stat;
         mask_ff   <= nxt_mask;
      end
   end

   // system reset request, one-cycle pulse on reset time-out
   always @(posedge aclk)
   begin
      if (!aresetn)
         sys_reset_req <= 1'b0;
      else
         sys_reset_req <= timeout && eff_re && !(eff_ie && !flag_ff);
   end

   // -----------------------------------------------------------------
   // interrupt outputs
   // -----------------------------------------------------------------
   assign wd_irq_req     = flag_ff & eff_ie & cpu_global_ie;
   assign wd_vector_addr = sys_reset_req ? `WDCU_VEC_RESET : `WDCU_VEC_TIMEOUT;
   assign irq            = |(stat_ff & mask_ff);

   // -----------------------------------------------------------------
   // axi read channel
   // -----------------------------------------------------------------
   assign ctrl_rd = {flag_ff, eff_ie, period_ff[3], unlock, eff_re, period_ff[2:0]};
   assign arready = ~rvalid;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= `WDCU_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp  <= mapped(araddr) ? `WDCU_RESP_OKAY : `WDCU_RESP_SLVERR;
         case (reg_sel(araddr))
            `WDCU_ADDR_CTRL:     rdata <= {24'h0, ctrl_rd};
            `WDCU_ADDR_CAUSE:    rdata <= {31'h0, cause_ff};
            `WDCU_ADDR_IRQ_STAT: rdata <= {30'h0, stat_ff};
            `WDCU_ADDR_IRQ_MASK: rdata <= {30'h0, mask_ff};
            `WDCU_ADDR_STATUS:   rdata <= {28'h0, run, flag_ff, eff_re, eff_ie};
            default:             rdata <= 32'h0;
         endcase
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end

endmodule

// ==== verification/wdcu_props.sv ====
// checker for the watchdog control unit: port-level timing relations.
// assumes a bind from the bench top and one aclk domain.
`timescale 1ns/100ps
`include "wdcu_defines.vh"
module wdcu_props (
   input logic        aclk,              // clock
   input logic        aresetn,           // sync reset, low
   input logic        wd_always_on_fuse, // fuse
   input logic        cpu_global_ie,     // global enable
   input logic        vector_taken,      // vector pulse
   input logic        awvalid,           // aw valid
   input logic        awready,           // aw ready
   input logic        wvalid,            // w valid
   input logic        wready,            // w ready
   input logic        bvalid,            // b valid
   input logic        arvalid,           // ar valid
   input logic        arready,           // ar ready
   input logic        rvalid,            // r valid
   input logic        wd_irq_req,        // irq request
   input logic [15:0] wd_vector_addr,    // vector
   input logic        sys_reset_req,     // reset request
   input logic        irq                // summary irq
);
   // -----------------------------------------------------------
   // properties
   // -----------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_rst_pulse; sys_reset_req |=> !sys_reset_req; endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
   property p_rst_vec; sys_reset_req |-> wd_vector_addr == `WDCU_VEC_RESET; endproperty
   a_rst_vec: assert property (p_rst_vec) else $error("bad reset vector");
   property p_irq_vec; wd_irq_req && !sys_reset_req |-> wd_vector_addr == `WDCU_VEC_TIMEOUT; endproperty
   a_irq_vec: assert property (p_irq_vec) else $error("bad irq vector");
   property p_irq_gie; wd_irq_req |-> cpu_global_ie; endproperty
   a_irq_gie: assert property (p_irq_gie) else $error("request without global enable");
   property p_vec_clr; vector_taken && wd_irq_req |=> !wd_irq_req; endproperty
   a_vec_clr: assert property (p_vec_clr) else $error("vector left request up");
   property p_fuse; wd_always_on_fuse [*3] |-> !wd_irq_req; endproperty
   a_fuse: assert property (p_fuse) else $error("irq with fuse set");
   property p_wresp; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
   a_wresp: assert property (p_wresp) else $error("late write response");
   property p_rresp; arvalid && arready |=> rvalid; endproperty
   a_rresp: assert property (p_rresp) else $error("late read data");

   // main scenarios reached
   c_rst: cover property (sys_reset_req);
   c_vec: cover property (vector_taken && wd_irq_req);
   c_irq: cover property (irq);
endmodule

// ==== verification/tb_watchdog_control_unit.sv ====
// bench for the watchdog control unit: axi4-lite register tests.
// assumes the checker module and the design files are compiled first.
`timescale 1ns/100ps
`include "wdcu_defines.vh"
module tb_watchdog_control_unit;
   localparam logic [31:0] CTL = `WDCU_ADDR_CTRL;
   localparam logic [31:0] CAU = `WDCU_ADDR_CAUSE;
   localparam logic [31:0] IST = `WDCU_ADDR_IRQ_STAT;
   localparam logic [31:0] IMK = `WDCU_ADDR_IRQ_MASK;
   logic        aclk = 1'b0, aresetn = 1'b0, wd_always_on_fuse = 1'b0;
   logic        cpu_global_ie = 1'b0, vector_taken = 1'b0, wd_restart = 1'b0;
   logic        osc_tick = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
   logic        arvalid = 1'b0, rready = 1'b1;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd_val;
   logic [3:0]  wstrb = 4'h1;
   logic        awready, wready, bvalid, arready, rvalid, wd_irq_req, sys_reset_req, irq;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata;
   logic [15:0] wd_vector_addr, rst_vec;
   int          errors = 0, tests_run = 0, rst_cnt = 0;

   always #4 aclk = ~aclk;

   wdcu_watchdog_control_unit dut (.*);

   // count reset requests and keep the vector shown with each
   always @(posedge aclk)
   begin
      if (sys_reset_req === 1'b1)
      begin
         rst_cnt <= rst_cnt + 1;
         rst_vec <= wd_vector_addr;
      end
   end

   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      rsp = bresp;
   endtask

   task rd(input logic [31:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rsp    = rresp;
      rd_val = rdata;
   endtask

   task rdc(input logic [31:0] a, input logic [31:0] e, input string m);
      rd(a);
      chk(rd_val, e, m);
   endtask

   // oscillator cycles, each a one-cycle pulse, then settle
   task tick(input int n);
      repeat (n)
      begin
         @(posedge aclk);
         osc_tick <= 1'b1;
         @(posedge aclk);
         osc_tick <= 1'b0;
      end
      repeat (4) @(posedge aclk);
   endtask

   // one-cycle restart and vector pulses
   task pls(input logic r, input logic v);
      wd_restart   <= r;
      vector_taken <= v;
      @(posedge aclk);
      wd_restart   <= 1'b0;
      vector_taken <= 1'b0;
   endtask

   task fin(input string n);
      $display("test %s done", n);
   endtask

   task test_done;
      $display("tests_run %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // -----------------------------------------------------------
   // tests
   // -----------------------------------------------------------
   initial
   begin
      #400000;
      errors++;
      $display("CHECK FAILED at %0t: run too long", $time);
      test_done;
   end

   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdc(CTL, 32'h0, "ctrl reset");
      chk(rsp, `WDCU_RESP_OKAY, "read resp");
      rdc(CAU, 32'h0, "cause reset");
      rd(32'h20);
      chk(rsp, `WDCU_RESP_SLVERR, "unmapped read");
      wr(32'h20, 32'h0);
      chk(rsp, `WDCU_RESP_SLVERR, "unmapped write");
      fin("reset");
      // interrupt mode, shortest period edge, status, mask, clears
      wr(CTL, 32'h40);
      wr(IMK, 32'h1);
      pls(1'b1, 1'b0);
      tick(2047);
      rdc(CTL, 32'h40, "flag early");
      tick(1);
      rdc(CTL, 32'hc0, "flag at period");
      chk(wd_irq_req, 1'b0, "request w/o global");
      cpu_global_ie <= 1'b1;
      rdc(IST, 32'h1, "irq status");
      chk(wd_irq_req, 1'b1, "request");
      chk(wd_vector_addr, `WDCU_VEC_TIMEOUT, "irq vector");
      chk(irq, 1'b1, "irq line");
      wr(IMK, 32'h0);
      chk(irq, 1'b0, "irq masked");
      wr(IST, 32'h1);
      wr(IMK, 32'h1);
      chk(irq, 1'b0, "irq cleared");
      wr(CTL, 32'h40);
      rdc(CTL, 32'hc0, "zero keeps flag");
      wr(CTL, 32'hc0);
      rdc(CTL, 32'h40, "one clears flag");
      pls(1'b1, 1'b0);
      tick(2048);
      pls(1'b0, 1'b1);
      rdc(CTL, 32'h40, "vector clears flag");
      fin("irq");
      // reset mode, cause flag, unlock window
      wr(CTL, 32'h08);
      pls(1'b1, 1'b0);
      tick(2048);
      chk(rst_cnt, 1, "reset request");
      chk(rst_vec, `WDCU_VEC_RESET, "reset vector");
      rdc(CAU, 32'h1, "cause set");
      rdc(IST, 32'h3, "reset event status");
      wr(CTL, 32'h18);
      wr(CTL, 32'h00);
      rdc(CTL, 32'h08, "cause forces re");
      wr(CAU, 32'h0);
      rdc(CTL, 32'h08, "re kept after cause clear");
      wr(CTL, 32'h18);
      repeat (8) @(posedge aclk);
      wr(CTL, 32'h00);
      rdc(CTL, 32'h08, "window expired");
      wr(CTL, 32'h18);
      wr(CTL, 32'h27);
      rdc(CTL, 32'h27, "period field");
      wr(CTL, 32'h20);
      rdc(CTL, 32'h27, "locked period");
      fin("unlock");
      // combined mode: vector drops to reset mode, unserved resets
      wr(CTL, 32'h3f);
      wr(CTL, 32'h48);
      rdc(CTL, 32'h48, "timed change");
      pls(1'b1, 1'b0);
      tick(2048);
      rdc(CTL, 32'hc8, "combined first");
      chk(rst_cnt, 1, "no reset yet");
      pls(1'b0, 1'b1);
      rdc(CTL, 32'h08, "vector clears ie");
      wr(CTL, 32'h48);
      pls(1'b1, 1'b0);
      tick(2048);
      tick(2048);
      chk(rst_cnt, 2, "unserved reset");
      fin("combined");
      // fuse locks reset-only mode
      wd_always_on_fuse <= 1'b1;
      wr(CTL, 32'h40);
      rd(32'h10);
      chk(rd_val[1:0], 2'b10, "fuse enables");
      chk(wd_irq_req, 1'b0, "fuse no request");
      fin("fuse");
      test_done;
   end
endmodule

bind wdcu_watchdog_control_unit wdcu_props u_props (.*);
